// File: verilog/ocs_pkg.sv
package ocs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // bus geometry
  localparam int          ADDR_W  = 20;
  localparam int          DATA_W  = 32;
  localparam int          STRB_W  = DATA_W / 8;
  localparam int          IDX_W   = ADDR_W - 2;

  ////////////////////////////////////////////////////////////////////////////
  // register indices, byte address is four times the index
  localparam logic [15:0] IDX_OFF_CAUSE  = 16'h400F;
  localparam logic [15:0] IDX_SUMMARY    = 16'h4010;
  localparam logic [15:0] IDX_EVT_STATUS = 16'h4080;
  localparam logic [15:0] IDX_EVT_MASK   = 16'h4081;
  localparam logic [15:0] IDX_EVT_RISE   = 16'h4082;
  localparam logic [15:0] IDX_EVT_FALL   = 16'h4083;

  ////////////////////////////////////////////////////////////////////////////
  // off-cause field positions, input order of the cause vector
  localparam int          N_CAUSE        = 7;
  localparam int          OFF_REG_ERR_BIT = 13;
  localparam int          OFF_SEQ_BIT    = 12;
  localparam int          OFF_GPIN_BIT   = 11;
  localparam int          OFF_SUPPLY_BIT = 10;
  localparam int          OFF_TEMP_BIT   = 9;
  localparam int          OFF_SW_BIT     = 6;
  localparam int          OFF_BUTTON_BIT = 4;
  localparam int          CAUSE_POS [N_CAUSE] = '{
    OFF_REG_ERR_BIT, OFF_SEQ_BIT, OFF_GPIN_BIT, OFF_SUPPLY_BIT,
    OFF_TEMP_BIT, OFF_SW_BIT, OFF_BUTTON_BIT};

  ////////////////////////////////////////////////////////////////////////////
  // summary field positions
  localparam int          SUM_W          = 16;
  localparam int          SUM_PS_BIT     = 15;
  localparam int          SUM_THERM_BIT  = 14;
  localparam int          SUM_GPIN_BIT   = 13;
  localparam int          SUM_BUTTON_BIT = 12;
  localparam int          SUM_WDOG_BIT   = 11;
  localparam int          SUM_AUX_BIT    = 8;
  localparam int          SUM_PPATH_BIT  = 7;
  localparam int          SUM_RTC_BIT    = 5;
  localparam int          SUM_OTP_BIT    = 4;
  localparam int          SUM_HC_BIT     = 1;
  localparam int          SUM_UV_BIT     = 0;

  ////////////////////////////////////////////////////////////////////////////
  // secondary event sources and their group membership per summary bit
  localparam int          N_SRC          = 32;
  localparam logic [N_SRC-1:0] GRP_MEMBERS [SUM_W] = '{
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
  localparam logic [N_SRC-1:0] MEM_PS     = 32'h0000_0007;
  localparam logic [N_SRC-1:0] MEM_THERM  = 32'h0000_0008;
  localparam logic [N_SRC-1:0] MEM_GPIN   = 32'h0000_00F0;
  localparam logic [N_SRC-1:0] MEM_BUTTON = 32'h0000_0100;
  localparam logic [N_SRC-1:0] MEM_WDOG   = 32'h0000_0200;
  localparam logic [N_SRC-1:0] MEM_AUX    = 32'h0000_7C00;
  localparam logic [N_SRC-1:0] MEM_PPATH  = 32'h0001_8000;
  localparam logic [N_SRC-1:0] MEM_RTC    = 32'h000E_0000;
  localparam logic [N_SRC-1:0] MEM_OTP    = 32'h0030_0000;
  localparam logic [N_SRC-1:0] MEM_HC     = 32'h00C0_0000;
  localparam logic [N_SRC-1:0] MEM_UV     = 32'hFF00_0000;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [SUM_W-1:0] RST_OFF_CAUSE  = 16'h0000;
  localparam logic [N_SRC-1:0] RST_EVT_STATUS = 32'h0000_0000;
  localparam logic [N_SRC-1:0] RST_EVT_MASK   = 32'hFFFF_FFFF;
  localparam logic [N_SRC-1:0] RST_EVT_RISE   = 32'hFFFF_FFFF;
  localparam logic [N_SRC-1:0] RST_EVT_FALL   = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // bus answers and register selection
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [6:0] {
    SEL_NONE   = 7'h01,
    SEL_CAUSE  = 7'h02,
    SEL_SUM    = 7'h04,
    SEL_STATUS = 7'h08,
    SEL_MASK   = 7'h10,
    SEL_RISE   = 7'h20,
    SEL_FALL   = 7'h40
  } ocs_sel_t;

endpackage

// File: verilog/ocs_top.sv
`timescale 1ns/1ps

module ocs_top
  import ocs_pkg::*;
(
  // clock and reset
  input  wire logic                REF_CLK_IN,
  input  wire logic                RESETN_IN,
  // power state machine
  input  wire logic                OFF_EVENT_IN,
  input  wire logic [N_CAUSE-1:0]  OFF_CAUSE_IN,
  input  wire logic                CAUSE_CLEAR_IN,
  // raw event sources
  input  wire logic [N_SRC-1:0]    EVENT_SRC_IN,
  // axi4-lite write address
  input  wire logic                AXI_AWVALID_IN,
  output logic                     AXI_AWREADY_OUT,
  input  wire logic [ADDR_W-1:0]   AXI_AWADDR_IN,
  input  wire logic [2:0]          AXI_AWPROT_IN,
  // axi4-lite write data
  input  wire logic                AXI_WVALID_IN,
  output logic                     AXI_WREADY_OUT,
  input  wire logic [DATA_W-1:0]   AXI_WDATA_IN,
  input  wire logic [STRB_W-1:0]   AXI_WSTRB_IN,
  // axi4-lite write response
  output logic                     AXI_BVALID_OUT,
  input  wire logic                AXI_BREADY_IN,
  output logic [1:0]               AXI_BRESP_OUT,
  // axi4-lite read address
  input  wire logic                AXI_ARVALID_IN,
  output logic                     AXI_ARREADY_OUT,
  input  wire logic [ADDR_W-1:0]   AXI_ARADDR_IN,
  input  wire logic [2:0]          AXI_ARPROT_IN,
  // axi4-lite read data
  output logic                     AXI_RVALID_OUT,
  input  wire logic                AXI_RREADY_IN,
  output logic [DATA_W-1:0]        AXI_RDATA_OUT,
  output logic [1:0]               AXI_RRESP_OUT,
  // interrupt
  output logic                     IRQ_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // word index decode, shared by read and write paths
  function automatic ocs_sel_t decode_sel(input logic [ADDR_W-1:0] addr);
    logic [IDX_W-1:0] idx;
    idx = addr[ADDR_W-1:2];
    if (idx == IDX_W'(IDX_OFF_CAUSE)) begin
      return SEL_CAUSE;
    end else if (idx == IDX_W'(IDX_SUMMARY)) begin
      return SEL_SUM;
    end else if (idx == IDX_W'(IDX_EVT_STATUS)) begin
      return SEL_STATUS;
    end else if (idx == IDX_W'(IDX_EVT_MASK)) begin
      return SEL_MASK;
    end else if (idx == IDX_W'(IDX_EVT_RISE)) begin
      return SEL_RISE;
    end else if (idx == IDX_W'(IDX_EVT_FALL)) begin
      return SEL_FALL;
    end else begin
      return SEL_NONE;
    end
  endfunction

  // byte lane mask from write strobes
  function automatic logic [DATA_W-1:0] lane_mask(input logic [STRB_W-1:0] strb);
    logic [DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < STRB_W; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [SUM_W-1:0]  off_cause_r;
  logic [SUM_W-1:0]  off_cause_nxt;
  logic [SUM_W-1:0]  summary;
  logic [N_SRC-1:0]  sync1_r;
  logic [N_SRC-1:0]  sync2_r;
  logic [N_SRC-1:0]  sync3_r;
  logic [N_SRC-1:0]  level_r;
  logic [N_SRC-1:0]  agree;
  logic [N_SRC-1:0]  rise;
  logic [N_SRC-1:0]  fall;
  logic [N_SRC-1:0]  evt_set;
  logic [N_SRC-1:0]  evt_clr;
  logic [N_SRC-1:0]  evt_status_r;
  logic [N_SRC-1:0]  evt_mask_r;
  logic [N_SRC-1:0]  evt_rise_r;
  logic [N_SRC-1:0]  evt_fall_r;
  logic              irq_r;
  logic              aw_held_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic              w_held_r;
  logic [DATA_W-1:0] w_data_r;
  logic [STRB_W-1:0] w_strb_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              rvalid_r;
  logic [DATA_W-1:0] rdata_r;
  logic [1:0]        rresp_r;
  logic              do_write;
  logic              do_read;
  ocs_sel_t          wr_sel;
  ocs_sel_t          rd_sel;
  logic [DATA_W-1:0] wr_lanes;
  logic [DATA_W-1:0] wr_bits;

  ////////////////////////////////////////////////////////////////////////////
  // off-cause record

  // cause vector lands on its documented bit positions
  always_comb begin
    off_cause_nxt = '0;
    for (int i = 0; i < N_CAUSE; i++) begin
      off_cause_nxt[CAUSE_POS[i]] = OFF_CAUSE_IN[i];
    end
  end

  // a new event beats a clear in the same cycle so no cause is lost
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      off_cause_r <= RST_OFF_CAUSE;
    end else if (OFF_EVENT_IN) begin
      off_cause_r <= off_cause_nxt;
    end else if (CAUSE_CLEAR_IN) begin
      off_cause_r <= RST_OFF_CAUSE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // source synchronisers and edge detection

  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
    end else begin
      sync1_r <= EVENT_SRC_IN;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // a change counts only once stages two and three agree
  assign agree = ~(sync2_r ^ sync3_r);
  assign rise  = agree & sync3_r & ~level_r;
  assign fall  = agree & ~sync3_r & level_r;

  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      level_r <= '0;
    end else begin
      level_r <= (agree & sync3_r) | (~agree & level_r);
    end
  end

  assign evt_set = (rise & evt_rise_r) | (fall & evt_fall_r);

  ////////////////////////////////////////////////////////////////////////////
  // secondary status, sticky, write one to clear

  assign evt_clr = (do_write && wr_sel == SEL_STATUS) ? wr_bits : '0;

  // set wins over clear in the same cycle
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      evt_status_r <= RST_EVT_STATUS;
    end else begin
      evt_status_r <= (evt_status_r & ~evt_clr) | evt_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // summary flags, one OR per group

  generate
    for (genvar b = 0; b < SUM_W; b++) begin : g_sum
      localparam logic [N_SRC-1:0] MEMB =
        (b == SUM_PS_BIT)     ? MEM_PS     :
        (b == SUM_THERM_BIT)  ? MEM_THERM  :
        (b == SUM_GPIN_BIT)   ? MEM_GPIN   :
        (b == SUM_BUTTON_BIT) ? MEM_BUTTON :
        (b == SUM_WDOG_BIT)   ? MEM_WDOG   :
        (b == SUM_AUX_BIT)    ? MEM_AUX    :
        (b == SUM_PPATH_BIT)  ? MEM_PPATH  :
        (b == SUM_RTC_BIT)    ? MEM_RTC    :
        (b == SUM_OTP_BIT)    ? MEM_OTP    :
        (b == SUM_HC_BIT)     ? MEM_HC     :
        (b == SUM_UV_BIT)     ? MEM_UV     : GRP_MEMBERS[b];
      assign summary[b] = |(evt_status_r & MEMB);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  assign wr_lanes = lane_mask(w_strb_r);
  assign wr_bits  = w_data_r & wr_lanes;

  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      evt_mask_r <= RST_EVT_MASK;
    end else if (do_write && wr_sel == SEL_MASK) begin
      evt_mask_r <= (evt_mask_r & ~wr_lanes) | wr_bits;
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      evt_rise_r <= RST_EVT_RISE;
    end else if (do_write && wr_sel == SEL_RISE) begin
      evt_rise_r <= (evt_rise_r & ~wr_lanes) | wr_bits;
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      evt_fall_r <= RST_EVT_FALL;
    end else if (do_write && wr_sel == SEL_FALL) begin
      evt_fall_r <= (evt_fall_r & ~wr_lanes) | wr_bits;
    end
  end

  // mask bit set means the source stays off the interrupt line
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(evt_status_r & ~evt_mask_r);
    end
  end

  assign IRQ_OUT = irq_r;

  ////////////////////////////////////////////////////////////////////////////
  // write channel, address and data taken in either order

  assign AXI_AWREADY_OUT = ~aw_held_r & ~bvalid_r;
  assign AXI_WREADY_OUT  = ~w_held_r & ~bvalid_r;
  assign do_write        = aw_held_r & w_held_r & ~bvalid_r;
  assign wr_sel          = decode_sel(aw_addr_r);

  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
    end else if (AXI_AWVALID_IN && AXI_AWREADY_OUT) begin
      aw_held_r <= 1'b1;
      aw_addr_r <= AXI_AWADDR_IN;
    end else if (do_write) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      w_held_r <= 1'b0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end else if (AXI_WVALID_IN && AXI_WREADY_OUT) begin
      w_held_r <= 1'b1;
      w_data_r <= AXI_WDATA_IN;
      w_strb_r <= AXI_WSTRB_IN;
    end else if (do_write) begin
      w_held_r <= 1'b0;
    end
  end

  // read-only registers accept writes silently, the cause stays untouched
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r  <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (AXI_BREADY_IN) begin
      bvalid_r <= 1'b0;
    end
  end

  assign AXI_BVALID_OUT = bvalid_r;
  assign AXI_BRESP_OUT  = bresp_r;

  ////////////////////////////////////////////////////////////////////////////
  // read channel

  assign AXI_ARREADY_OUT = ~rvalid_r;
  assign do_read         = AXI_ARVALID_IN & ~rvalid_r;
  assign rd_sel          = decode_sel(AXI_ARADDR_IN);

  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
      rresp_r  <= RESP_OKAY;
    end else if (do_read) begin
      rvalid_r <= 1'b1;
      rresp_r  <= RESP_OKAY;
      case (rd_sel)
        SEL_CAUSE: begin
          rdata_r <= {16'h0000, off_cause_r};
        end
        SEL_SUM: begin
          rdata_r <= {16'h0000, summary};
        end
        SEL_STATUS: begin
          rdata_r <= evt_status_r;
        end
        SEL_MASK: begin
          rdata_r <= evt_mask_r;
        end
        SEL_RISE: begin
          rdata_r <= evt_rise_r;
        end
        SEL_FALL: begin
          rdata_r <= evt_fall_r;
        end
        default: begin
          rdata_r <= '0;
          rresp_r <= RESP_SLVERR;
        end
      endcase
    end else if (AXI_RREADY_IN) begin
      rvalid_r <= 1'b0;
    end
  end

  assign AXI_RVALID_OUT = rvalid_r;
  assign AXI_RDATA_OUT  = rdata_r;
  assign AXI_RRESP_OUT  = rresp_r;

endmodule

// File: bench/ocs_top_asserts.sv
`timescale 1ns/1ps
module ocs_checker
  import ocs_pkg::*;
(
  // clock and reset
  input  wire logic               REF_CLK_IN,
  input  wire logic               RESETN_IN,
  // state machine
  input  wire logic               OFF_EVENT_IN,
  input  wire logic [N_CAUSE-1:0] OFF_CAUSE_IN,
  input  wire logic               CAUSE_CLEAR_IN,
  // write side
  input  wire logic               AXI_AWVALID_IN,
  input  wire logic               AXI_AWREADY_OUT,
  input  wire logic               AXI_WVALID_IN,
  input  wire logic               AXI_WREADY_OUT,
  input  wire logic               AXI_BVALID_OUT,
  input  wire logic               AXI_BREADY_IN,
  input  wire logic [1:0]         AXI_BRESP_OUT,
  // read side
  input  wire logic               AXI_ARVALID_IN,
  input  wire logic               AXI_ARREADY_OUT,
  input  wire logic [ADDR_W-1:0]  AXI_ARADDR_IN,
  input  wire logic               AXI_RVALID_OUT,
  input  wire logic               AXI_RREADY_IN,
  input  wire logic [DATA_W-1:0]  AXI_RDATA_OUT,
  input  wire logic [1:0]         AXI_RRESP_OUT
);
  logic [15:0]      cause_m;
  logic [IDX_W-1:0] ar_idx;
  logic             ar_map;
  int               pos [N_CAUSE] = '{13, 12, 11, 10, 9, 6, 4};

  assign ar_idx = AXI_ARADDR_IN[ADDR_W-1:2];
  assign ar_map = ar_idx inside {IDX_W'(IDX_OFF_CAUSE), IDX_W'(IDX_SUMMARY),
    IDX_W'(IDX_EVT_STATUS), IDX_W'(IDX_EVT_MASK), IDX_W'(IDX_EVT_RISE), IDX_W'(IDX_EVT_FALL)};

  ////////////////////////////////////////////////////////////////////////////
  // reference copy of the cause record; event wins over clear
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      cause_m <= 16'h0000;
    end else if (OFF_EVENT_IN) begin
      for (int i = 0; i < N_CAUSE; i++) begin
        cause_m[pos[i]] <= OFF_CAUSE_IN[i];
      end
      cause_m[15:14] <= 2'h0;
      cause_m[8:7] <= 2'h0;
      cause_m[5] <= 1'b0;
      cause_m[3:0] <= 4'h0;
    end else if (CAUSE_CLEAR_IN) begin
      cause_m <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  sequence ar_taken;
    AXI_ARVALID_IN && AXI_ARREADY_OUT;
  endsequence
  sequence wr_taken;
    AXI_AWVALID_IN && AXI_AWREADY_OUT && AXI_WVALID_IN && AXI_WREADY_OUT;
  endsequence

  // address and data sit one cycle in the holding registers before the write lands
  chk_b_follows: assert property (wr_taken |-> ##2 AXI_BVALID_OUT)
    else $error("write response late");
  chk_b_holds: assert property (AXI_BVALID_OUT && !AXI_BREADY_IN
    |=> AXI_BVALID_OUT && $stable(AXI_BRESP_OUT)) else $error("write response dropped");
  chk_b_blocks: assert property (AXI_BVALID_OUT |-> !AXI_AWREADY_OUT && !AXI_WREADY_OUT)
    else $error("write taken while response pending");
  chk_r_follows: assert property (ar_taken |=> AXI_RVALID_OUT)
    else $error("read data late");
  chk_r_holds: assert property (AXI_RVALID_OUT && !AXI_RREADY_IN |=> AXI_RVALID_OUT
    && $stable(AXI_RDATA_OUT) && $stable(AXI_RRESP_OUT)) else $error("read data dropped");
  chk_ar_blocks: assert property (AXI_RVALID_OUT |-> !AXI_ARREADY_OUT)
    else $error("read taken while data pending");
  chk_cause_value: assert property (
    ar_taken ##0 (ar_idx == IDX_W'(IDX_OFF_CAUSE))
    |=> AXI_RDATA_OUT == {16'h0000, $past(cause_m)} && AXI_RRESP_OUT == RESP_OKAY)
    else $error("cause record wrong");
  chk_unmapped_err: assert property (ar_taken ##0 !ar_map
    |=> AXI_RRESP_OUT == RESP_SLVERR && AXI_RDATA_OUT == 32'h0000_0000)
    else $error("unmapped read not refused");
endmodule

bind ocs_top ocs_checker u_chk (.*);

// File: bench/ocs_host.sv
`timescale 1ns/1ps
module ocs_host
  import ocs_pkg::*;
(
  // clock
  input  wire logic              clk_in,
  // write channels
  output logic                   awvalid_out,
  input  wire logic              awready_in,
  output logic [ADDR_W-1:0]      awaddr_out,
  output logic                   wvalid_out,
  input  wire logic              wready_in,
  output logic [DATA_W-1:0]      wdata_out,
  input  wire logic              bvalid_in,
  output logic                   bready_out,
  input  wire logic [1:0]        bresp_in,
  // read channels
  output logic                   arvalid_out,
  input  wire logic              arready_in,
  output logic [ADDR_W-1:0]      araddr_out,
  input  wire logic              rvalid_in,
  output logic                   rready_out,
  input  wire logic [DATA_W-1:0] rdata_in,
  input  wire logic [1:0]        rresp_in
);
  // cycles of stall before taking an answer
  int lag = 0;

  initial begin
    awvalid_out = 1'b0;
    wvalid_out = 1'b0;
    arvalid_out = 1'b0;
    bready_out = 1'b0;
    rready_out = 1'b0;
    awaddr_out = '0;
    araddr_out = '0;
    wdata_out = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // released payload is inverted so a stale value is never mistaken
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                    output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awvalid_out <= 1'b1;
    awaddr_out <= a;
    wvalid_out <= 1'b1;
    wdata_out <= d;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_in);
      if (!aw_ok && awready_in) begin
        aw_ok = 1'b1;
        awvalid_out <= 1'b0;
        awaddr_out <= ~a;
      end
      if (!w_ok && wready_in) begin
        w_ok = 1'b1;
        wvalid_out <= 1'b0;
        wdata_out <= ~d;
      end
    end
    repeat (lag) @(posedge clk_in);
    bready_out <= 1'b1;
    do @(posedge clk_in); while (!(bvalid_in && bready_out));
    r = bresp_in;
    bready_out <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
                    output logic [1:0] r);
    arvalid_out <= 1'b1;
    araddr_out <= a;
    do @(posedge clk_in); while (!arready_in);
    arvalid_out <= 1'b0;
    araddr_out <= ~a;
    repeat (lag) @(posedge clk_in);
    rready_out <= 1'b1;
    do @(posedge clk_in); while (!(rvalid_in && rready_out));
    d = rdata_in;
    r = rresp_in;
    rready_out <= 1'b0;
  endtask
endmodule

// File: bench/tb_ocs_top.sv
`timescale 1ns/1ps
module tb_ocs_top;
  import ocs_pkg::*;
  localparam logic [ADDR_W-1:0] A_CAUSE = {2'b00, IDX_OFF_CAUSE, 2'b00};
  localparam logic [ADDR_W-1:0] A_SUM   = {2'b00, IDX_SUMMARY, 2'b00};
  localparam logic [ADDR_W-1:0] A_STAT  = {2'b00, IDX_EVT_STATUS, 2'b00};
  localparam logic [ADDR_W-1:0] A_MASK  = {2'b00, IDX_EVT_MASK, 2'b00};
  localparam logic [ADDR_W-1:0] A_FALL  = {2'b00, IDX_EVT_FALL, 2'b00};
  localparam logic [ADDR_W-1:0] A_RISE  = {2'b00, IDX_EVT_RISE, 2'b00};
  localparam logic [ADDR_W-1:0] A_BAD   = 20'h00010;

  logic               clk, rst_n, off_evt, clr, irq;
  logic [N_CAUSE-1:0] cause_v;
  logic [N_SRC-1:0]   src;
  logic               awvalid, awready, wvalid, wready, bvalid, bready;
  logic               arvalid, arready, rvalid, rready;
  logic [ADDR_W-1:0]  awaddr, araddr;
  logic [DATA_W-1:0]  wdata, rdata, rd_d;
  logic [1:0]         bresp, rresp, rsp;
  int                 error_cnt = 0;
  int                 comparisons = 0;
  int                 pos [N_CAUSE] = '{13, 12, 11, 10, 9, 6, 4};
  int                 g_src [11] = '{0, 3, 4, 8, 9, 10, 15, 17, 20, 22, 24};
  int                 g_sum [11] = '{15, 14, 13, 12, 11, 8, 7, 5, 4, 1, 0};

  ocs_top dut (.REF_CLK_IN(clk), .RESETN_IN(rst_n), .OFF_EVENT_IN(off_evt),
    .OFF_CAUSE_IN(cause_v), .CAUSE_CLEAR_IN(clr), .EVENT_SRC_IN(src),
    .AXI_AWVALID_IN(awvalid), .AXI_AWREADY_OUT(awready), .AXI_AWADDR_IN(awaddr),
    .AXI_AWPROT_IN(3'h0), .AXI_WVALID_IN(wvalid), .AXI_WREADY_OUT(wready),
    .AXI_WDATA_IN(wdata), .AXI_WSTRB_IN(4'hF), .AXI_BVALID_OUT(bvalid),
    .AXI_BREADY_IN(bready), .AXI_BRESP_OUT(bresp), .AXI_ARVALID_IN(arvalid),
    .AXI_ARREADY_OUT(arready), .AXI_ARADDR_IN(araddr), .AXI_ARPROT_IN(3'h0),
    .AXI_RVALID_OUT(rvalid), .AXI_RREADY_IN(rready), .AXI_RDATA_OUT(rdata),
    .AXI_RRESP_OUT(rresp), .IRQ_OUT(irq));

  ocs_host host (.clk_in(clk), .awvalid_out(awvalid), .awready_in(awready),
    .awaddr_out(awaddr), .wvalid_out(wvalid), .wready_in(wready), .wdata_out(wdata),
    .bvalid_in(bvalid), .bready_out(bready), .bresp_in(bresp), .arvalid_out(arvalid),
    .arready_in(arready), .araddr_out(araddr), .rvalid_in(rvalid), .rready_out(rready),
    .rdata_in(rdata), .rresp_in(rresp));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    host.rd(a, rd_d, rsp);
    check(rd_d, exp);
    check(32'(rsp), 32'(RESP_OKAY));
  endtask

  task automatic wr_ok(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    host.wr(a, d, rsp);
    check(32'(rsp), 32'(RESP_OKAY));
  endtask

  // an edge passes after each pulse so pulses never collide
  task automatic pulse(input logic e, input logic [N_CAUSE-1:0] v, input logic c);
    off_evt <= e;
    cause_v <= v;
    clr <= c;
    @(posedge clk);
    off_evt <= 1'b0;
    clr <= 1'b0;
    cause_v <= ~v;
    @(posedge clk);
  endtask

  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // whole run is a few hundred cycles, far inside the 20000-cycle limit
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    report_and_stop();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    off_evt = 1'b0;
    clr = 1'b0;
    cause_v = '0;
    src = '0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd_chk(A_CAUSE, 32'h0000_0000);
    rd_chk(A_SUM, 32'h0000_0000);
    rd_chk(A_STAT, RST_EVT_STATUS);
    rd_chk(A_MASK, RST_EVT_MASK);
    rd_chk(A_RISE, RST_EVT_RISE);
    for (int i = 0; i < N_CAUSE; i++) begin
      pulse(1'b1, 7'(1 << i), 1'b0);
      rd_chk(A_CAUSE, 32'(1) << pos[i]);
    end
    pulse(1'b1, 7'h7F, 1'b0);
    host.lag = 3;
    wr_ok(A_CAUSE, 32'h0000_0000);
    rd_chk(A_CAUSE, 32'h0000_3E50);
    host.lag = 0;
    pulse(1'b1, 7'h01, 1'b1);
    rd_chk(A_CAUSE, 32'h0000_2000);
    pulse(1'b0, 7'h00, 1'b1);
    rd_chk(A_CAUSE, 32'h0000_0000);
    host.rd(A_BAD, rd_d, rsp);
    check(rd_d, 32'h0000_0000);
    check(32'(rsp), 32'(RESP_SLVERR));
    host.wr(A_BAD, 32'h0000_0001, rsp);
    check(32'(rsp), 32'(RESP_SLVERR));
    // every group raised, then cleared by writing one
    wr_ok(A_MASK, 32'h0000_0000);
    for (int g = 0; g < 11; g++) begin
      src[g_src[g]] <= 1'b1;
      repeat (6) @(posedge clk);
      rd_chk(A_SUM, 32'(1) << g_sum[g]);
      check(32'(irq), 32'h1);
      wr_ok(A_STAT, 32'(1) << g_src[g]);
      src[g_src[g]] <= 1'b0;
      repeat (6) @(posedge clk);
      rd_chk(A_SUM, 32'h0000_0000);
      check(32'(irq), 32'h0);
    end
    // two members pending: flag holds until both cleared
    src[11:10] <= 2'h3;
    repeat (6) @(posedge clk);
    wr_ok(A_STAT, 32'h0000_0400);
    rd_chk(A_SUM, 32'h0000_0100);
    wr_ok(A_STAT, 32'h0000_0800);
    rd_chk(A_SUM, 32'h0000_0000);
    // masked source: flag shows but no interrupt
    wr_ok(A_MASK, 32'hFFFF_FFFF);
    wr_ok(A_FALL, 32'h0000_0008);
    src[3] <= 1'b1;
    repeat (6) @(posedge clk);
    check(32'(irq), 32'h0);
    wr_ok(A_STAT, 32'h0000_0008);
    src[3] <= 1'b0;
    repeat (6) @(posedge clk);
    rd_chk(A_STAT, 32'h0000_0008);
    rd_chk(A_SUM, 32'h0000_4000);
    // rise disabled on one source: its edge must leave status alone
    wr_ok(A_STAT, 32'h0000_0008);
    wr_ok(A_RISE, 32'hFFFF_FDFF);
    rd_chk(A_RISE, 32'hFFFF_FDFF);
    src[9] <= 1'b1;
    repeat (6) @(posedge clk);
    rd_chk(A_STAT, 32'h0000_0000);
    rd_chk(A_SUM, 32'h0000_0000);
    report_and_stop();
  end
endmodule
